// ===== tamp_pkg.sv
// Package for the two-axis motion protection supervisor: constants and carrier types.
package tamp_pkg;
    localparam int TAMP_AXES = 2;
    localparam int TAMP_POS_W = 32;
    localparam int TAMP_ERR_W = 15;
    localparam logic [TAMP_ERR_W-1:0] TAMP_ERR_LIMIT_RESET = 15'h4000;
    localparam logic [TAMP_ERR_W-1:0] TAMP_ERR_LIMIT_MIN = 15'h0001;
    localparam logic [TAMP_POS_W-1:0] TAMP_POS_MAX = 32'h7fffffff;
    localparam logic [TAMP_POS_W-1:0] TAMP_POS_MIN = 32'h80000000;
    localparam logic [TAMP_POS_W-1:0] TAMP_ZERO_POS = 32'h00000000;
    localparam logic [1:0] TAMP_ZERO_AX = 2'h0;
    // Sample period in ns, then in reference clocks
    localparam int TAMP_SAMPLE_NS = 1000;
    localparam int TAMP_CLK_NS = 20;
    localparam int TAMP_SAMPLE_CYC = TAMP_SAMPLE_NS / TAMP_CLK_NS;
    localparam logic [7:0] TAMP_SAMPLE_LAST = 8'(TAMP_SAMPLE_CYC - 1);

    typedef enum {TAMP_MAIN, TAMP_FAULT_HND, TAMP_LIMSW} tamp_exec_t;

    // Host command group
    typedef struct packed {
        logic [TAMP_AXES-1:0] set_fwd_limit;
        logic [TAMP_AXES-1:0] set_rev_limit;
        logic [TAMP_AXES-1:0] set_err_limit;
        logic [TAMP_AXES-1:0] set_off_on_error;
        logic [TAMP_POS_W-1:0] value;
        logic [TAMP_AXES-1:0] servo_here_request;
        logic [TAMP_AXES-1:0] pos_cmd_valid;
        logic [TAMP_POS_W-1:0] pos_cmd_target;
        logic motor_off;
        logic abort_cmd;
        logic return_from_handler;
        logic program_running;
    } tamp_cmd_t;

    // Per-axis servo feedback
    typedef struct packed {
        logic [TAMP_POS_W-1:0] actual;
        logic [TAMP_POS_W-1:0] profile;
        logic fwd_motion;
        logic rev_motion;
    } tamp_axis_in_t;
endpackage

// ===== tamp_supervisor.sv
// Two-axis motion protection supervisor: limits, off-on-error, handler vectoring.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Reject position commands beyond programmed limits
// - Stop motion at programmed position limit
// - Off-on-error bit per axis, 1 enables
// - Off-on-error disables motor on error/abort
// - Servo-here re-enables, clears error, loads position
// - Excess error vectors to position-fault handler
// - Return resumes main program where left
// - Handler re-entered while error persists
// - Fault handler only while program runs
// - Active limit switch inhibits that direction
// - A switch going active while none was active vectors to switch handler
// - Switch states readable per axis
// - Switch polarity set by configuration
// - Switch handler only while program runs
// - Error limit 1..32767, resets to 16384
// - Abort pin stops motion at the next sample tick; others hold position
// - Low switch means active by default
// - Shared amplifier enable drops on faults
module tamp_supervisor
    import tamp_pkg::*;
#(
    parameter int AXES = TAMP_AXES
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tamp_cmd_t cmd,
    input wire tamp_axis_in_t [AXES-1:0] axis_in,
    input wire logic [AXES-1:0] fwd_switch_n,
    input wire logic [AXES-1:0] rev_switch_n,
    input wire logic abort_n,
    input wire logic watchdog_trip,
    input wire logic [AXES-1:0] switch_polarity_config,
    output logic amplifier_enable_output,
    output logic [AXES-1:0] motor_enabled,
    output logic [AXES-1:0] fwd_inhibit,
    output logic [AXES-1:0] rev_inhibit,
    output logic [AXES-1:0] motion_stop,
    output logic [AXES-1:0] forward_switch_state,
    output logic [AXES-1:0] reverse_switch_state,
    output logic [AXES-1:0] excess_error,
    output logic [AXES-1:0] pos_cmd_reject,
    output logic [AXES-1:0] pos_cmd_accept,
    output logic [AXES-1:0] commanded_load,
    output logic [TAMP_POS_W-1:0] commanded_value,
    output logic [1:0] exec_vector,
    output logic resume_main
);

    typedef struct packed {
        logic [2:0][AXES-1:0] fwd_sync;
        logic [2:0][AXES-1:0] rev_sync;
        logic [2:0] abort_sync;
        logic [AXES-1:0] fwd_stable;
        logic [AXES-1:0] rev_stable;
        logic abort_stable;
        logic [7:0] tick_cnt;
        logic [AXES-1:0][TAMP_POS_W-1:0] fwd_limit;
        logic [AXES-1:0][TAMP_POS_W-1:0] rev_limit;
        logic [AXES-1:0] fwd_set;
        logic [AXES-1:0] rev_set;
        logic [AXES-1:0][TAMP_ERR_W-1:0] err_limit;
        logic [AXES-1:0][TAMP_POS_W-1:0] cmd_offset;
        logic [AXES-1:0] off_on_error;
        logic [AXES-1:0] motor_on;
        logic [AXES-1:0] fwd_inh;
        logic [AXES-1:0] rev_inh;
        logic [AXES-1:0] stop;
        logic [AXES-1:0] excess;
        logic [AXES-1:0] reject;
        logic [AXES-1:0] accept;
        logic [AXES-1:0] load;
        logic [TAMP_POS_W-1:0] load_val;
        logic amp_en;
        logic any_sw_prev;
        tamp_exec_t exec;
        logic resume;
    } tamp_state_t;

    tamp_state_t st;
    tamp_state_t next_st;

    // Absolute value of a signed difference, kept at the full position width, not saturated
    function automatic logic [TAMP_POS_W-1:0] tamp_abs_diff(
        input logic [TAMP_POS_W-1:0] a,
        input logic [TAMP_POS_W-1:0] b
    );
        logic [TAMP_POS_W-1:0] d;
        d = a - b;
        return d[TAMP_POS_W-1] ? (TAMP_POS_W'(0) - d) : d;
    endfunction

    // Signed compare a > b
    function automatic logic tamp_gt(
        input logic [TAMP_POS_W-1:0] a,
        input logic [TAMP_POS_W-1:0] b
    );
        return $signed(a) > $signed(b);
    endfunction

    // Next-state logic
    always_comb
    begin
        logic tick;
        logic any_sw;
        logic any_err;
        logic [AXES-1:0] sw_fwd;
        logic [AXES-1:0] sw_rev;
        logic [TAMP_POS_W-1:0] cmd_pos;
        tick = 1'b0;
        any_sw = 1'b0;
        any_err = 1'b0;
        sw_fwd = '0;
        sw_rev = '0;
        cmd_pos = '0;
        next_st = st;
        next_st.resume = 1'b0;
        next_st.reject = '0;
        next_st.accept = '0;
        next_st.load = '0;

        // Three-stage synchronisers; change taken when stages 2 and 3 agree
        next_st.fwd_sync = {st.fwd_sync[1:0], fwd_switch_n};
        next_st.rev_sync = {st.rev_sync[1:0], rev_switch_n};
        next_st.abort_sync = {st.abort_sync[1:0], abort_n};
        for (int i = 0; i < AXES; i++)
        begin
            if (st.fwd_sync[1][i] == st.fwd_sync[2][i])
                next_st.fwd_stable[i] = st.fwd_sync[2][i];
            if (st.rev_sync[1][i] == st.rev_sync[2][i])
                next_st.rev_stable[i] = st.rev_sync[2][i];
        end
        if (st.abort_sync[1] == st.abort_sync[2])
            next_st.abort_stable = st.abort_sync[2];

        // Sample-period divider
        if (st.tick_cnt == TAMP_SAMPLE_LAST)
        begin
            next_st.tick_cnt = 8'h00;
            tick = 1'b1;
        end
        else
            next_st.tick_cnt = st.tick_cnt + 8'h01;

        // Active switch: low by default, polarity bit inverts
        sw_fwd = ~st.fwd_stable ^ switch_polarity_config;
        sw_rev = ~st.rev_stable ^ switch_polarity_config;
        any_sw = |{sw_fwd, sw_rev};

        for (int i = 0; i < AXES; i++)
        begin
            // Configuration commands
            if (cmd.set_fwd_limit[i])
            begin
                next_st.fwd_limit[i] = cmd.value;
                next_st.fwd_set[i] = 1'b1;
            end
            if (cmd.set_rev_limit[i])
            begin
                next_st.rev_limit[i] = cmd.value;
                next_st.rev_set[i] = 1'b1;
            end
            if (cmd.set_err_limit[i] && cmd.value[TAMP_POS_W-1:TAMP_ERR_W] == '0
                && cmd.value[TAMP_ERR_W-1:0] >= TAMP_ERR_LIMIT_MIN)
                next_st.err_limit[i] = cmd.value[TAMP_ERR_W-1:0];
            if (cmd.set_off_on_error[i])
                next_st.off_on_error[i] = cmd.value[0];

            // Position command screening against programmed limits
            if (cmd.pos_cmd_valid[i])
            begin
                if ((st.fwd_set[i] && tamp_gt(cmd.pos_cmd_target, st.fwd_limit[i]))
                    || (st.rev_set[i] && tamp_gt(st.rev_limit[i], cmd.pos_cmd_target)))
                    next_st.reject[i] = 1'b1;
                else
                    next_st.accept[i] = 1'b1;
            end

            // Per-sample checks
            cmd_pos = axis_in[i].profile + st.cmd_offset[i];
            if (tick)
            begin
                next_st.excess[i] = tamp_abs_diff(cmd_pos, axis_in[i].actual)
                    > {17'h00000, st.err_limit[i]};
                next_st.fwd_inh[i] = sw_fwd[i]
                    || (st.fwd_set[i] && !tamp_gt(st.fwd_limit[i], cmd_pos));
                next_st.rev_inh[i] = sw_rev[i]
                    || (st.rev_set[i] && !tamp_gt(cmd_pos, st.rev_limit[i]));
                next_st.stop[i] = (next_st.fwd_inh[i] && axis_in[i].fwd_motion)
                    || (next_st.rev_inh[i] && axis_in[i].rev_motion)
                    || !st.abort_stable;
            end

            // Off-on-error shutdown; motor off command for every axis
            if (st.off_on_error[i] && (st.excess[i] || cmd.abort_cmd || !st.abort_stable))
                next_st.motor_on[i] = 1'b0;
            if (cmd.motor_off)
                next_st.motor_on[i] = 1'b0;

            // Servo here: commanded position follows encoder
            if (cmd.servo_here_request[i])
            begin
                next_st.motor_on[i] = 1'b1;
                next_st.cmd_offset[i] = axis_in[i].actual - axis_in[i].profile;
                next_st.excess[i] = 1'b0;
                next_st.load[i] = 1'b1;
                next_st.load_val = axis_in[i].actual;
            end
        end
        any_err = |st.excess;

        // Shared amplifier enable, held low while any axis is off
        next_st.amp_en = !(cmd.motor_off || any_err || watchdog_trip
            || (|(~st.motor_on)));

        // Handler vectoring, only while a program runs
        next_st.any_sw_prev = any_sw;
        case (st.exec)
            TAMP_MAIN:
            begin
                if (cmd.program_running && any_err)
                    next_st.exec = TAMP_FAULT_HND;
                else if (cmd.program_running && any_sw && !st.any_sw_prev)
                    next_st.exec = TAMP_LIMSW;
            end
            TAMP_FAULT_HND, TAMP_LIMSW:
            begin
                if (!cmd.program_running)
                    next_st.exec = TAMP_MAIN;
                else if (cmd.return_from_handler)
                begin
                    next_st.exec = TAMP_MAIN;
                    next_st.resume = 1'b1;
                end
            end
            default:
                next_st.exec = TAMP_MAIN;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.fwd_sync <= '1;
            st.rev_sync <= '1;
            st.abort_sync <= 3'h7;
            st.fwd_stable <= '1;
            st.rev_stable <= '1;
            st.abort_stable <= 1'b1;
            st.err_limit <= {AXES{TAMP_ERR_LIMIT_RESET}};
            st.motor_on <= '1;
            st.amp_en <= 1'b1;
            st.exec <= TAMP_MAIN;
        end
        else
            st <= next_st;
    end

    // Outputs straight from state
    always_comb
    begin
        amplifier_enable_output = st.amp_en;
        motor_enabled = st.motor_on;
        fwd_inhibit = st.fwd_inh;
        rev_inhibit = st.rev_inh;
        motion_stop = st.stop;
        forward_switch_state = st.fwd_stable;
        reverse_switch_state = st.rev_stable;
        excess_error = st.excess;
        pos_cmd_reject = st.reject;
        pos_cmd_accept = st.accept;
        commanded_load = st.load;
        commanded_value = st.load_val;
        exec_vector = (st.exec == TAMP_FAULT_HND) ? 2'h1 : (st.exec == TAMP_LIMSW) ? 2'h2 : 2'h0;
        resume_main = st.resume;
    end

endmodule
`default_nettype wire

// ===== tamp_field_model.sv
// Far-side model: limit switch pins and abort pin from requested states.
`timescale 1ns/1ps
`default_nettype none
module tamp_field_model
(
    input wire logic [1:0] fwd_act,
    input wire logic [1:0] rev_act,
    input wire logic abort_act,
    input wire logic [1:0] switch_polarity_config,
    output logic [1:0] fwd_switch_n,
    output logic [1:0] rev_switch_n,
    output logic abort_n
);
    // Switch pin level from active state and configured polarity; abort pin is active low
    assign fwd_switch_n = ~(fwd_act ^ switch_polarity_config);
    assign rev_switch_n = ~(rev_act ^ switch_polarity_config);
    assign abort_n = ~abort_act;
endmodule
`default_nettype wire

// ===== tamp_supervisor_assertions.sv
// Assertion checker for the motion protection supervisor ports.
`timescale 1ns/1ps
`default_nettype none
module tamp_supervisor_checker
    import tamp_pkg::*;
#(
    parameter int AXES = TAMP_AXES
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tamp_cmd_t cmd,
    input wire tamp_axis_in_t [AXES-1:0] axis_in,
    input wire logic watchdog_trip,
    input wire logic amplifier_enable_output,
    input wire logic [AXES-1:0] motor_enabled,
    input wire logic [AXES-1:0] pos_cmd_reject,
    input wire logic [AXES-1:0] pos_cmd_accept,
    input wire logic [AXES-1:0] commanded_load,
    input wire logic [TAMP_POS_W-1:0] commanded_value,
    input wire logic [1:0] exec_vector,
    input wire logic resume_main
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Command answers, loads and handler moves against their causes
    reject_cause_a: assert property (pos_cmd_reject[0] |-> $past(cmd.pos_cmd_valid[0]))
        else $error("reject without request");
    one_answer_a: assert property (cmd.pos_cmd_valid[0] |=> pos_cmd_reject[0] ^ pos_cmd_accept[0])
        else $error("position command not answered once");
    load_value_a: assert property (commanded_load[1] |-> commanded_value == $past(axis_in[1].actual))
        else $error("loaded value differs from actual");
    load_cause_a: assert property (commanded_load == $past(cmd.servo_here_request))
        else $error("load does not follow servo here");
    motor_off_a: assert property (cmd.motor_off |=> ##[0:2] motor_enabled == '0)
        else $error("motor off did not disable axes");
    watchdog_amp_a: assert property (watchdog_trip |-> ##[1:3] !amplifier_enable_output)
        else $error("watchdog left amplifier enabled");
    amp_follow_a: assert property (!(&motor_enabled) |-> ##[0:2] !amplifier_enable_output)
        else $error("amplifier enabled with axis off");
    resume_cause_a: assert property (resume_main |-> $past(cmd.return_from_handler) && exec_vector == 2'h0)
        else $error("resume without return");
    entry_running_a: assert property (exec_vector != 2'h0 && $past(exec_vector) == 2'h0 |-> $past(cmd.program_running))
        else $error("handler entered without program");
endmodule
bind tamp_supervisor tamp_supervisor_checker #(.AXES(AXES)) checker_i (.ref_clk, .nrst, .cmd,
    .axis_in, .watchdog_trip, .amplifier_enable_output, .motor_enabled, .pos_cmd_reject,
    .pos_cmd_accept, .commanded_load, .commanded_value, .exec_vector, .resume_main);
`default_nettype wire

// ===== test_tamp_supervisor.sv
// Self-checking bench for the motion protection supervisor.
`timescale 1ns/1ps
`default_nettype none
module test_tamp_supervisor
    import tamp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    tamp_cmd_t cmd = '0;
    tamp_axis_in_t [1:0] axis_in = '0;
    logic [1:0] fwd_act = 2'h0;
    logic [1:0] rev_act = 2'h0;
    logic [1:0] switch_polarity_config = 2'h0;
    logic abort_act = 1'b0;
    logic watchdog_trip = 1'b0;
    logic [1:0] fwd_switch_n, rev_switch_n, motor_enabled, fwd_inhibit, rev_inhibit;
    logic [1:0] forward_switch_state, reverse_switch_state, excess_error, pos_cmd_reject;
    logic [1:0] pos_cmd_accept, commanded_load, exec_vector, motion_stop;
    logic abort_n, amplifier_enable_output, resume_main;
    logic [31:0] commanded_value;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    tamp_field_model field (.fwd_act, .rev_act, .abort_act, .switch_polarity_config,
        .fwd_switch_n, .rev_switch_n, .abort_n);
    tamp_supervisor #(.AXES(2)) dut (.ref_clk, .nrst, .cmd, .axis_in, .fwd_switch_n,
        .rev_switch_n, .abort_n, .watchdog_trip, .switch_polarity_config,
        .amplifier_enable_output, .motor_enabled, .fwd_inhibit, .rev_inhibit, .motion_stop,
        .forward_switch_state, .reverse_switch_state, .excess_error, .pos_cmd_reject,
        .pos_cmd_accept, .commanded_load, .commanded_value, .exec_vector, .resume_main);
    always #10 ref_clk = ~ref_clk;
    // Verdict and end of run
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Strobes stand one edge, then the answer cycle passes
    task automatic pulse;
        cyc(1);
        cmd = '{program_running: cmd.program_running, default: '0};
        cyc(1);
    endtask
    // Answer stands one cycle: judged before the strobe drops
    task automatic pcmd(input logic [31:0] t, input logic r);
        cmd.pos_cmd_valid = 2'h1;
        cmd.pos_cmd_target = t;
        cyc(1);
        check("pos_cmd_reject", 32'(pos_cmd_reject), 32'(r));
        check("pos_cmd_accept", 32'(pos_cmd_accept), 32'(!r));
        cmd = '{program_running: cmd.program_running, default: '0};
        cyc(1);
    endtask
    // Return from handler; resume pulse judged in its one cycle
    task automatic handler_return;
        cmd.return_from_handler = 1'b1;
        cyc(1);
        check("resume_main", 32'(resume_main), 32'h1);
        cmd = '{program_running: cmd.program_running, default: '0};
        cyc(2);
    endtask
    // Limits at 2000 and -2000, commands on and past each
    task automatic t_limits;
        cmd.set_fwd_limit = 2'h1;
        cmd.value = 32'h000007d0;
        pulse;
        cmd.set_rev_limit = 2'h1;
        cmd.value = 32'hfffff830;
        pulse;
        pcmd(32'h000007d1, 1'b1);
        pcmd(32'h000007d0, 1'b0);
        pcmd(32'hfffff82f, 1'b1);
        pcmd(32'hfffff830, 1'b0);
        // Axis 0 driven onto each limit while moving toward it
        for (int d = 0; d < 2; d++)
        begin
            axis_in[0].profile = (d == 0) ? 32'h000007d0 : 32'hfffff830;
            axis_in[0].fwd_motion = (d == 0);
            axis_in[0].rev_motion = (d == 1);
            cyc(60);
            check("fwd_inhibit", 32'(fwd_inhibit), 32'(d == 0));
            check("rev_inhibit", 32'(rev_inhibit), 32'(d == 1));
            check("motion_stop", 32'(motion_stop), 32'h1);
        end
        axis_in[0] = '0;
        cyc(60);
        check("motion_stop", 32'(motion_stop), 32'h0);
    endtask
    // Abort command, abort pin, motor off; then servo here
    task automatic t_faults;
        cmd.set_off_on_error = 2'h2;
        cmd.value = 32'h1;
        pulse;
        for (int c = 0; c < 3; c++)
        begin
            cmd.abort_cmd = (c == 0);
            abort_act = (c == 1);
            cmd.motor_off = (c == 2);
            pulse;
            cyc(6);
            check("motor_enabled", 32'(motor_enabled), (c == 2) ? 32'h0 : 32'h1);
            check("amplifier_enable_output", 32'(amplifier_enable_output), 32'h0);
            cyc(50);
            check("motion_stop", 32'(motion_stop), (c == 1) ? 32'h3 : 32'h0);
            abort_act = 1'b0;
            cyc(6);
            axis_in[0].actual = 32'h100 + 32'(c);
            axis_in[0].profile = axis_in[0].actual;
            axis_in[1] = axis_in[0];
            cmd.servo_here_request = (c == 2) ? 2'h3 : 2'h2;
            pulse;
            check("commanded_value", commanded_value, axis_in[1].actual);
            cyc(3);
            check("motor_enabled", 32'(motor_enabled), 32'h3);
        end
    endtask
    // Excess error on axis 0: entry, re-entry, boundary, no program
    task automatic t_position_fault_handler;
        cmd.set_err_limit = 2'h1;
        cmd.value = 32'h64;
        pulse;
        cmd.set_err_limit = 2'h1;
        cmd.value = 32'h0;
        pulse;
        cmd.program_running = 1'b1;
        axis_in[0].actual = axis_in[0].profile + 32'h65;
        cyc(60);
        check("excess_error", 32'(excess_error), 32'h1);
        check("exec_vector", 32'(exec_vector), 32'h1);
        handler_return;
        check("exec_vector", 32'(exec_vector), 32'h1);
        axis_in[0].actual = axis_in[0].profile + 32'h64;
        cyc(60);
        check("excess_error", 32'(excess_error), 32'h0);
        handler_return;
        check("exec_vector", 32'(exec_vector), 32'h0);
        cmd.program_running = 1'b0;
        axis_in[0].actual = axis_in[0].profile + 32'h65;
        cyc(60);
        check("exec_vector", 32'(exec_vector), 32'h0);
        axis_in[0].actual = axis_in[0].profile;
        cyc(60);
    endtask
    // Switches at both polarities; 60 cycles spans sync and one tick
    task automatic t_switch;
        cmd.program_running = 1'b1;
        fwd_act = 2'h1;
        cyc(60);
        check("exec_vector", 32'(exec_vector), 32'h2);
        check("forward_switch_state", 32'(forward_switch_state), 32'h2);
        check("fwd_inhibit", 32'(fwd_inhibit), 32'h1);
        check("rev_inhibit", 32'(rev_inhibit), 32'h0);
        handler_return;
        check("exec_vector", 32'(exec_vector), 32'h0);
        switch_polarity_config = 2'h3;
        fwd_act = 2'h0;
        cyc(60);
        check("fwd_inhibit", 32'(fwd_inhibit), 32'h0);
        rev_act = 2'h2;
        cyc(60);
        check("rev_inhibit", 32'(rev_inhibit), 32'h2);
        check("reverse_switch_state", 32'(reverse_switch_state), 32'h2);
        check("exec_vector", 32'(exec_vector), 32'h2);
    endtask
    // Cycle ceiling against a hang
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            stop_test;
        end
    end
    // Main sequence
    initial
    begin
        cyc(6);
        nrst = 1'b1;
        check("amplifier_enable_output", 32'(amplifier_enable_output), 32'h1);
        check("motor_enabled", 32'(motor_enabled), 32'h3);
        t_limits;
        t_faults;
        t_position_fault_handler;
        t_switch;
        check("amplifier_enable_output", 32'(amplifier_enable_output), 32'h1);
        watchdog_trip = 1'b1;
        cyc(4);
        check("amplifier_enable_output", 32'(amplifier_enable_output), 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire
